/* File: acs_cfg.svh */
// Constants of the conversion sequencer: register offsets, field positions, reset values, timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

`define ACS_OFF_CTRL      12'h000
`define ACS_OFF_STATUS    12'h004
`define ACS_OFF_RESULT    12'h008
`define ACS_OFF_IRQ_STAT  12'h00C
`define ACS_OFF_IRQ_MASK  12'h010
`define ACS_OFF_PMD       12'h014

`define ACS_CTRL_ON       0
`define ACS_CTRL_GO       1
`define ACS_CTRL_TRIG     2
`define ACS_CTRL_RC       3
`define ACS_CTRL_ACQ_LO   4
`define ACS_CTRL_CLK_LO   8
`define ACS_CTRL_RESET    32'h0000_0000

`define ACS_IRQ_DONE      0
`define ACS_IRQ_ABORT     1
`define ACS_IRQ_BITS      2

`define ACS_RESULT_BITS   10
`define ACS_WAIT_PERIODS  4'h2
`define ACS_INSTR_CYCLES  8'h04
`define ACS_RC_DIV        8'h40
`define ACS_AXI_OKAY      2'h0
`define ACS_AXI_SLVERR    2'h2

`endif

/* File: acs_pkg.sv */
// Types of the conversion sequencer.
// Assumes acs_cfg.svh is on the include path.
package acs_pkg;
	`include "acs_cfg.svh"
	typedef enum logic [2:0] {
		ACS_IDLE    = 3'b000,
		ACS_ARM     = 3'b001,
		ACS_ACQUIRE = 3'b010,
		ACS_CONVERT = 3'b011,
		ACS_WAIT    = 3'b100
	} acs_state_e;
endpackage

/* File: acs_sequencer.sv */
// Control logic of a successive-approximation converter with an AXI4-Lite register slave.
// Assumes the analogue comparator, compare unit and charge-time unit sit on core_clk.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "acs_cfg.svh"

module acs_sequencer
	import acs_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Start triggers, one-cycle pulses
	input  wire logic        compare_unit_event,
	input  wire logic        charge_time_event,
	// Power management
	input  wire logic        sleep_active,
	output logic             wake_request,
	// Analogue core
	input  wire logic        sar_bit_in,
	output logic             sample_connect,
	output logic             sar_clk_en,
	output logic             analog_power,
	// Interrupt
	output logic             irq
);

	logic                          go_q;
	logic                          converter_on_q;
	logic                          trigger_source_select_q;
	logic                          rc_select_q;
	logic [2:0]                    acquisition_time_select_q;
	logic [2:0]                    conversion_clock_select_q;
	logic                          converter_module_disable_q;
	logic [`ACS_RESULT_BITS-1:0]   result_q;
	logic [`ACS_RESULT_BITS-1:0]   shift_q;
	logic [`ACS_IRQ_BITS-1:0]      irq_stat_q;
	logic [`ACS_IRQ_BITS-1:0]      irq_mask_q;
	acs_state_e                    state_q;
	logic [7:0]                    div_q;
	logic [7:0]                    tick_q;
	logic [4:0]                    cnt_q;
	logic                          powered_down_q;

	// Module disable acts as a local synchronous reset
	logic rst;
	assign rst = !resetn || converter_module_disable_q;

	// Conversion bit period enable from divider
	logic [7:0] div_limit;
	logic       tad_tick;
	logic       sw_abort;
	logic       sleep_abort;
	always_comb begin
		if (rc_select_q) begin
			div_limit = `ACS_RC_DIV;
		end else begin
			div_limit = 8'h01 << conversion_clock_select_q;
		end
	end
	assign tad_tick = (div_q >= div_limit - 8'h01);

	always_ff @(posedge core_clk) begin
		// An abort restarts the period so the wait after it is two full periods
		if (rst || state_q == ACS_IDLE || state_q == ACS_ARM || sw_abort || sleep_abort) begin
			div_q <= 8'h00;
		end else if (tad_tick) begin
			div_q <= 8'h00;
		end else begin
			div_q <= div_q + 8'h01;
		end
	end

	// AXI write path
	logic        aw_held_q;
	logic        w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic        wr_fire;
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			awaddr_q      <= 12'h000;
			wdata_q       <= 32'h0000_0000;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ACS_AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				s_axi_awready <= 1'b0;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				s_axi_wready <= 1'b0;
				wdata_q  <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q > `ACS_OFF_PMD) ? `ACS_AXI_SLVERR : `ACS_AXI_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic wr_pmd;
	assign wr_ctrl = wr_fire && awaddr_q == `ACS_OFF_CTRL;
	assign wr_stat = wr_fire && awaddr_q == `ACS_OFF_IRQ_STAT;
	assign wr_mask = wr_fire && awaddr_q == `ACS_OFF_IRQ_MASK;
	assign wr_pmd  = wr_fire && awaddr_q == `ACS_OFF_PMD;

	// Module disable survives its own reset so software can release it
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			converter_module_disable_q <= 1'b0;
		end else if (wr_pmd) begin
			converter_module_disable_q <= wdata_q[0];
		end
	end

	// Control fields
	always_ff @(posedge core_clk) begin
		if (rst) begin
			converter_on_q            <= 1'b0;
			trigger_source_select_q   <= 1'b0;
			rc_select_q               <= 1'b0;
			acquisition_time_select_q <= 3'h0;
			conversion_clock_select_q <= 3'h0;
		end else if (wr_ctrl) begin
			converter_on_q            <= wdata_q[`ACS_CTRL_ON];
			trigger_source_select_q   <= wdata_q[`ACS_CTRL_TRIG];
			rc_select_q               <= wdata_q[`ACS_CTRL_RC];
			acquisition_time_select_q <= wdata_q[`ACS_CTRL_ACQ_LO +: 3];
			conversion_clock_select_q <= wdata_q[`ACS_CTRL_CLK_LO +: 3];
		end
	end

	// Start sources
	logic hw_trigger;
	logic sw_start;
	assign hw_trigger  = converter_on_q
		&& (trigger_source_select_q ? charge_time_event : compare_unit_event);
	assign sw_start    = wr_ctrl && wdata_q[`ACS_CTRL_GO] && wdata_q[`ACS_CTRL_ON];
	assign sw_abort    = wr_ctrl && !wdata_q[`ACS_CTRL_GO] && go_q;
	assign sleep_abort = sleep_active && !rc_select_q && go_q;

	logic done_evt;
	assign done_evt = state_q == ACS_CONVERT && tad_tick && cnt_q == 5'd0;

	// Sequencer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= ACS_IDLE;
			cnt_q   <= 5'd0;
			tick_q  <= 8'h00;
			go_q    <= 1'b0;
			shift_q <= '0;
		end else if (sw_abort || sleep_abort) begin
			state_q <= ACS_WAIT;
			cnt_q   <= 5'(`ACS_WAIT_PERIODS);
			go_q    <= 1'b0;
		end else begin
			unique case (state_q)
				ACS_IDLE: begin
					if ((hw_trigger || sw_start) && !powered_down_q) begin
						go_q    <= 1'b1;
						state_q <= rc_select_q ? ACS_ARM : ACS_ACQUIRE;
						tick_q  <= `ACS_INSTR_CYCLES;
						cnt_q   <= {2'b00, acquisition_time_select_q} << 1;
					end
				end
				ACS_ARM: begin
					// One extra instruction lets sleep be entered before conversion noise
					if (tick_q == 8'h01) begin
						state_q <= ACS_ACQUIRE;
					end
					tick_q <= tick_q - 8'h01;
				end
				ACS_ACQUIRE: begin
					if (tad_tick) begin
						if (cnt_q == 5'd0) begin
							state_q <= ACS_CONVERT;
							cnt_q   <= 5'(`ACS_RESULT_BITS - 1);
						end else begin
							cnt_q <= cnt_q - 5'd1;
						end
					end
				end
				ACS_CONVERT: begin
					if (tad_tick) begin
						shift_q <= {shift_q[`ACS_RESULT_BITS-2:0], sar_bit_in};
						if (cnt_q == 5'd0) begin
							go_q    <= 1'b0;
							state_q <= ACS_WAIT;
							cnt_q   <= 5'(`ACS_WAIT_PERIODS);
						end else begin
							cnt_q <= cnt_q - 5'd1;
						end
					end
				end
				ACS_WAIT: begin
					if (tad_tick) begin
						if (cnt_q == 5'd1) begin
							state_q <= ACS_IDLE;
						end
						cnt_q <= cnt_q - 5'd1;
					end
				end
			endcase
		end
	end

	// Result only on full completion; an abort leaves the old value
	always_ff @(posedge core_clk) begin
		if (rst) begin
			result_q <= '0;
		end else if (done_evt && !sw_abort && !sleep_abort) begin
			result_q <= {shift_q[`ACS_RESULT_BITS-2:0], sar_bit_in};
		end
	end

	// Sleep power-down keeps converter_on_q set
	always_ff @(posedge core_clk) begin
		if (rst || !sleep_active) begin
			powered_down_q <= 1'b0;
		end else if (sleep_abort) begin
			powered_down_q <= 1'b1;
		end else if (done_evt && !irq_mask_q[`ACS_IRQ_DONE]) begin
			powered_down_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= sleep_active && done_evt && irq_mask_q[`ACS_IRQ_DONE];
		end
	end

	// Interrupt status; a new event beats a clear in the same cycle
	logic [`ACS_IRQ_BITS-1:0] irq_set;
	assign irq_set = {sw_abort || sleep_abort, done_evt && !sw_abort && !sleep_abort};
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~(wr_stat ? wdata_q[`ACS_IRQ_BITS-1:0] : '0))
				| irq_set;
			if (wr_mask) begin
				irq_mask_q <= wdata_q[`ACS_IRQ_BITS-1:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Analogue outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sample_connect <= 1'b0;
			sar_clk_en     <= 1'b0;
			analog_power   <= 1'b0;
		end else begin
			sample_connect <= state_q == ACS_ACQUIRE;
			sar_clk_en     <= state_q == ACS_CONVERT;
			analog_power   <= converter_on_q && !powered_down_q;
		end
	end

	// AXI read path
	logic [31:0] rd_mux;
	always_comb begin
		unique case (s_axi_araddr)
			`ACS_OFF_CTRL: begin
				rd_mux = {21'h0, conversion_clock_select_q, 1'b0, acquisition_time_select_q,
					rc_select_q, trigger_source_select_q, go_q, converter_on_q};
			end
			`ACS_OFF_STATUS:   rd_mux = {27'h0, powered_down_q, 1'b0, state_q};
			`ACS_OFF_RESULT:   rd_mux = {22'h0, result_q};
			`ACS_OFF_IRQ_STAT: rd_mux = {30'h0, irq_stat_q};
			`ACS_OFF_IRQ_MASK: rd_mux = {30'h0, irq_mask_q};
			`ACS_OFF_PMD:      rd_mux = {31'h0, converter_module_disable_q};
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `ACS_AXI_OKAY;
			s_axi_arready <= 1'b1;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= (s_axi_araddr > `ACS_OFF_PMD) ? `ACS_AXI_SLVERR : `ACS_AXI_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1; // A new address waits until the data is taken
		end
	end

endmodule

/* File: acs_sequencer_assertions.sv */
// Port checker of the conversion sequencer, bound to acs_sequencer.
// Assumes one clock domain, core_clk, and the synchronous active-low resetn.
`timescale 1ns/1ps
module acs_sequencer_chk (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        resetn,
	// Bus handshakes
	input wire logic        s_axi_arready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Converter side
	input wire logic        compare_unit_event,
	input wire logic        charge_time_event,
	input wire logic        sleep_active,
	input wire logic        wake_request,
	input wire logic        sample_connect,
	input wire logic        sar_clk_en,
	input wire logic        analog_power
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	sequence s_quiet;
		!sample_connect && !sar_clk_en;
	endsequence
	sequence s_held_off;
		s_quiet [*2];
	endsequence
	property p_phase_excl;
		!(sample_connect && sar_clk_en);
	endproperty
	property p_wait_after;
		$fell(sar_clk_en) |-> s_held_off;
	endproperty
	property p_off_ignore;
		!analog_power && (compare_unit_event || charge_time_event) |=> s_held_off;
	endproperty
	// Two low cycles give the power flag one cycle of slack against the phase outputs
	property p_powered_off;
		!analog_power [*2] |-> s_quiet;
	endproperty
	property p_wake_pulse;
		wake_request |-> $past(sleep_active) ##1 (!wake_request && !sar_clk_en);
	endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_ar_refuse;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_phase_excl: assert property (p_phase_excl)
		else $error("acquisition and conversion overlap");
	a_wait_after: assert property (p_wait_after)
		else $error("acquisition too soon after conversion");
	a_off_ignore: assert property (p_off_ignore)
		else $error("trigger started an unpowered converter");
	a_powered_off: assert property (p_powered_off)
		else $error("activity while converter is off");
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake pulse malformed");
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped");
	a_r_hold: assert property (p_r_hold)
		else $error("read response dropped");
	a_ar_refuse: assert property (p_ar_refuse)
		else $error("read address taken while data pending");
endmodule

bind acs_sequencer acs_sequencer_chk acs_sequencer_chk_i (.core_clk, .resetn, .s_axi_arready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.compare_unit_event, .charge_time_event, .sleep_active, .wake_request, .sample_connect,
	.sar_clk_en, .analog_power);

/* File: acs_trig_model.sv */
// Trigger sources and comparator seen by the sequencer.
// Assumes the bench requests pulses one cycle long, just after a clock edge.
`timescale 1ns/1ps
module acs_trig_model (
	// Clock
	input wire logic       core_clk,
	// Requests from the bench, and sar_clk_en from the sequencer
	input wire logic [3:0] cmp_mode,
	input wire logic       ctm_trig_en,
	input wire logic       cmp_fire,
	input wire logic       ctm_fire,
	input wire logic       level,
	input wire logic       sar_clk_en,
	// To the sequencer
	output logic           compare_unit_event,
	output logic           charge_time_event,
	output logic           sar_bit_in
);
	always_ff @(posedge core_clk) begin
		compare_unit_event <= cmp_fire && cmp_mode == 4'hB;
		charge_time_event  <= ctm_fire && ctm_trig_en;
		// Level changes only between conversions so a result is all ones or all zeros
		if (!sar_clk_en) begin
			sar_bit_in <= level;
		end
	end
endmodule

/* File: test_adc_conversion_sequencer.sv */
// Self-checking bench of the conversion sequencer over AXI4-Lite.
// Assumes acs_cfg.svh on the include path and a 100 MHz core_clk.
`timescale 1ns/1ps
`include "acs_cfg.svh"
module test_adc_conversion_sequencer;
	logic        core_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, sleep_active, cmp_fire, ctm_fire, level, ctm_trig_en;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        wake_request, sample_connect, sar_clk_en, analog_power, irq, sar_bit_in;
	logic        compare_unit_event, charge_time_event;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb, cmp_mode;
	logic [9:0]  res;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, ctl;
	logic [33:0] exp_q[$];
	int          errors, checked, seed, wakes;

	acs_sequencer acs_sequencer_i (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compare_unit_event, .charge_time_event,
		.sleep_active, .wake_request, .sar_bit_in, .sample_connect, .sar_clk_en, .analog_power,
		.irq);
	acs_trig_model acs_trig_model_i (.core_clk, .cmp_mode, .ctm_trig_en, .cmp_fire, .ctm_fire,
		.level, .sar_clk_en, .compare_unit_event, .charge_time_event, .sar_bit_in);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk; // Never stopped mid-conversion
	end

	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	// The expected word is noted first; the monitor below compares it
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask

	task automatic hold_for(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		// A wait that runs out counts as a mismatch
		chk({33'h0, s}, {33'h0, v});
	endtask

	always @(posedge core_clk) begin
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (wake_request === 1'b1) wakes++;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		close_out();
	end

	initial begin
		{resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{sleep_active, cmp_fire, ctm_fire, level, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{errors, checked, wakes} = '0;
		s_axi_wstrb = 4'hF;
		cmp_mode = 4'hB;
		ctm_trig_en = 1'b1;
		seed = 32'hafc0;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(12'(4 * i), i == 6 ? {`ACS_AXI_SLVERR, 32'h0} : 34'h0);
		$display("reset values done");
		level <= 1'($random(seed));
		ctl = 32'h1 | (32'($random(seed) & 7) << 4);
		wr(`ACS_OFF_IRQ_MASK, 32'h3);
		wr(`ACS_OFF_CTRL, ctl | 32'h2);
		hold_for(irq, 1'b1, 300);
		res = {10{level}};
		rd(`ACS_OFF_RESULT, {24'h0, res});
		rd(`ACS_OFF_CTRL, {2'h0, ctl});
		rd(`ACS_OFF_IRQ_STAT, 34'h1);
		wr(`ACS_OFF_IRQ_STAT, 32'h3);
		rd(`ACS_OFF_IRQ_STAT, 34'h0);
		$display("software conversion done");
		level <= ~level;
		wr(`ACS_OFF_CTRL, ctl | 32'h2);
		hold_for(sar_clk_en, 1'b1, 300);
		wr(`ACS_OFF_CTRL, ctl);
		hold_for(irq, 1'b1, 300);
		rd(`ACS_OFF_RESULT, {24'h0, res});
		rd(`ACS_OFF_IRQ_STAT, 34'h2);
		wr(`ACS_OFF_IRQ_STAT, 32'h3);
		$display("abort done");
		for (int i = 0; i < 6; i++) begin
			wr(`ACS_OFF_CTRL, {29'h0, i[0], 1'b0, i < 4});
			cmp_fire <= !i[1];
			ctm_fire <= i[1];
			@(posedge core_clk);
			cmp_fire <= 1'b0;
			ctm_fire <= 1'b0;
			repeat (40) @(posedge core_clk); // Long enough for a whole conversion
			rd(`ACS_OFF_IRQ_STAT, {33'h0, i < 4 && i[0] == i[1]});
			wr(`ACS_OFF_IRQ_STAT, 32'h3);
		end
		$display("triggers done");
		wr(`ACS_OFF_CTRL, 32'h73);
		sleep_active <= 1'b1;
		hold_for(analog_power, 1'b0, 300);
		rd(`ACS_OFF_IRQ_STAT, 34'h2);
		rd(`ACS_OFF_STATUS, 34'h10);
		rd(`ACS_OFF_CTRL, 34'h71);
		wr(`ACS_OFF_IRQ_STAT, 32'h3);
		sleep_active <= 1'b0;
		wr(`ACS_OFF_CTRL, 32'hB); // RC clock chosen before Sleep
		sleep_active <= 1'b1;
		hold_for(irq, 1'b1, 2000);
		rd(`ACS_OFF_IRQ_STAT, 34'h1);
		chk(34'(wakes), 34'h1);
		sleep_active <= 1'b0;
		wr(`ACS_OFF_IRQ_STAT, 32'h3);
		wr(`ACS_OFF_IRQ_MASK, 32'h0);
		// The two-period RC wait must run out; a start is refused until idle
		repeat (3 * `ACS_RC_DIV) @(posedge core_clk);
		wr(`ACS_OFF_CTRL, 32'hB);
		sleep_active <= 1'b1;
		hold_for(analog_power, 1'b0, 2000);
		rd(`ACS_OFF_STATUS, 34'h14); // Powered down, still in the wait
		rd(`ACS_OFF_CTRL, 34'h9);
		chk({33'h0, irq}, 34'h0);
		sleep_active <= 1'b0;
		$display("sleep done");
		wr(`ACS_OFF_PMD, 32'h1);
		wr(`ACS_OFF_CTRL, 32'h3);
		rd(`ACS_OFF_CTRL, 34'h0);
		rd(`ACS_OFF_PMD, 34'h1);
		wr(`ACS_OFF_PMD, 32'h0);
		$display("module disable done");
		close_out();
	end
endmodule
